//--- design/port_b_gpio_pin_mux.sv
// Port B general-purpose I/O with pin function multiplexing and AXI4-Lite registers
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "port_b_map.svh"
module port_b_gpio_pin_mux (
	input wire logic clk, // System clock, 40 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire logic hw_standby, // Hardware standby, clears the port registers as reset does
	input wire logic [21:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [21:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [7:0] pin_in, // Port B pin levels
	output logic [7:0] pin_out, // Port B drive levels
	output logic [7:0] pin_oe, // Port B output enables
	input wire logic [1:0] pa_pin_in, // Previous port pins 1..0 levels
	output logic [1:0] pa_pin_out, // Previous port pins 1..0 drive
	output logic [1:0] pa_pin_oe, // Previous port pins 1..0 enables
	input wire logic [7:0] pattern_latch, // Pattern unit bits 15..8
	input wire logic [1:0] pattern_latch_low, // Pattern unit bits 1..0
	input wire port_b_pkg::timer8_ctrl_t timer8_ch3, // Timer 8 channel 3 controls
	input wire logic timer8_ch1_ext_clock, // Timer 8 channel 1 uses external clock
	input wire port_b_pkg::timer16_ctrl_t timer16, // Timer 16 controls
	input wire logic chip_sel4_enable, // Chip select 4 enable
	input wire logic chip_select_four, // Chip select 4 level
	output logic timer8_ch3_io_pin, // Pin 3 level into timer channel 3
	output logic ext_timer_clock_a, // External clock A
	output logic ext_timer_clock_b // External clock B
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] port_direction_control_reg;
	logic [7:0] port_output_data_reg;
	logic [7:0] pattern_enable_reg;
	logic [1:0] pa_dir_reg;
	logic [1:0] pa_data_reg;
	logic [1:0] pat_low_reg;
	logic sw_standby_reg;
	logic [7:0] pin_sync_lvl;
	logic [1:0] pa_sync_lvl;
	logic [7:0] gp_drive;
	logic [7:0] gp_en;
	logic [1:0] pa_drive;
	logic [1:0] pa_en;
	logic clear_all;

	assign clear_all = reset || hw_standby;

	// ----------------------------------------------------------------
	// Pin input synchronisers
	// ----------------------------------------------------------------
	pin_sync #(.WIDTH(8)) u_sync_b (
		.clk(clk),
		.reset(reset),
		.async_in(pin_in),
		.sync_out(pin_sync_lvl)
	);

	pin_sync #(.WIDTH(2)) u_sync_a (
		.clk(clk),
		.reset(reset),
		.async_in(pa_pin_in),
		.sync_out(pa_sync_lvl)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	port_b_pkg::bus_state_t state_reg;
	logic [21:0] aw_hold_reg;
	logic [31:0] w_hold_reg;
	logic [3:0] wstrb_hold_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic do_write;
	logic [7:0] read_byte;
	logic read_hit;

	// Offsets are word indices, so the byte address is four times the index
	// and address bits 1:0 never select a register
	function automatic logic addr_known(input logic [21:0] a);
		addr_known = (a[21:2] == `DIR_CTRL_ADDR) || (a[21:2] == `OUT_DATA_ADDR)
			|| (a[21:2] == `PAT_EN_ADDR) || (a[21:2] == `SIDE_CTRL_ADDR)
			|| (a[21:2] == `PA_DIR_ADDR) || (a[21:2] == `PA_DATA_ADDR);
	endfunction : addr_known

	// Registers sit in byte lane 0, so only strobe 0 writes them
	function automatic logic word_match(input logic [21:0] a, input logic [19:0] index);
		word_match = a[21:2] == index;
	endfunction : word_match

	assign s_axi_awready = (state_reg == port_b_pkg::BUS_IDLE) && !aw_have_reg;
	assign s_axi_wready = (state_reg == port_b_pkg::BUS_IDLE) && !w_have_reg;
	assign s_axi_arready = (state_reg == port_b_pkg::BUS_IDLE) && !aw_have_reg && !w_have_reg;
	assign do_write = (state_reg == port_b_pkg::BUS_IDLE) && aw_have_reg && w_have_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_hold_reg <= 22'h000000;
			w_hold_reg <= 32'h00000000;
			wstrb_hold_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_hold_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_hold_reg <= s_axi_wdata;
				wstrb_hold_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= port_b_pkg::BUS_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h00000000;
		end else begin
			case (state_reg)
				port_b_pkg::BUS_IDLE: begin
					if (do_write) begin
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= addr_known(aw_hold_reg) ? 2'h0 : 2'h2;
						state_reg <= port_b_pkg::BUS_WRESP;
					end else if (s_axi_arvalid && s_axi_arready) begin
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= read_hit ? 2'h0 : 2'h2;
						s_axi_rdata <= {24'h000000, read_byte};
						state_reg <= port_b_pkg::BUS_RRESP;
					end
				end
				port_b_pkg::BUS_WRESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						state_reg <= port_b_pkg::BUS_IDLE;
					end
				end
				port_b_pkg::BUS_RRESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						state_reg <= port_b_pkg::BUS_IDLE;
					end
				end
				default: begin
					state_reg <= port_b_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		read_hit = addr_known(s_axi_araddr);
		read_byte = 8'h00;
		if (word_match(s_axi_araddr, `DIR_CTRL_ADDR)) begin
			read_byte = `DIR_READ_VALUE;
		end else if (word_match(s_axi_araddr, `OUT_DATA_ADDR)) begin
			read_byte = (port_direction_control_reg & port_output_data_reg)
				| (~port_direction_control_reg & pin_sync_lvl);
		end else if (word_match(s_axi_araddr, `PAT_EN_ADDR)) begin
			read_byte = pattern_enable_reg;
		end else if (word_match(s_axi_araddr, `SIDE_CTRL_ADDR)) begin
			read_byte = {5'h00, pat_low_reg, sw_standby_reg};
		end else if (word_match(s_axi_araddr, `PA_DIR_ADDR)) begin
			read_byte = {6'h00, pa_dir_reg};
		end else if (word_match(s_axi_araddr, `PA_DATA_ADDR)) begin
			read_byte = {6'h00, (pa_dir_reg & pa_data_reg) | (~pa_dir_reg & pa_sync_lvl)};
		end
	end

	// ----------------------------------------------------------------
	// Port register writes
	// ----------------------------------------------------------------
	logic wr_lane0;
	assign wr_lane0 = do_write && wstrb_hold_reg[0];

	always_ff @(posedge clk) begin
		if (clear_all) begin
			port_direction_control_reg <= `DIR_RESET;
		end else if (wr_lane0 && word_match(aw_hold_reg, `DIR_CTRL_ADDR)) begin
			port_direction_control_reg <= w_hold_reg[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			port_output_data_reg <= `DATA_RESET;
		end else if (wr_lane0 && word_match(aw_hold_reg, `OUT_DATA_ADDR)) begin
			port_output_data_reg <= w_hold_reg[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			pattern_enable_reg <= `PAT_RESET;
		end else if (wr_lane0 && word_match(aw_hold_reg, `PAT_EN_ADDR)) begin
			pattern_enable_reg <= w_hold_reg[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			sw_standby_reg <= 1'b0;
			pat_low_reg <= 2'h0;
		end else if (wr_lane0 && word_match(aw_hold_reg, `SIDE_CTRL_ADDR)) begin
			sw_standby_reg <= w_hold_reg[`SIDE_STANDBY_BIT];
			pat_low_reg <= w_hold_reg[2:1];
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			pa_dir_reg <= 2'h0;
			pa_data_reg <= 2'h0;
		end else if (wr_lane0 && word_match(aw_hold_reg, `PA_DIR_ADDR)) begin
			pa_dir_reg <= w_hold_reg[1:0];
		end else if (wr_lane0 && word_match(aw_hold_reg, `PA_DATA_ADDR)) begin
			pa_data_reg <= w_hold_reg[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Pin function selection
	// ----------------------------------------------------------------
	// Lower port B pins hold no pattern use here, so their enables are zero
	// eight pins, alternate functions
	pin_fn_sel #(.WIDTH(8)) u_sel_b (
		.dir(port_direction_control_reg),
		.pat_en({pattern_enable_reg[7:`PAT_HIGH_LSB], 3'h0}),
		.data(port_output_data_reg),
		.pat_data(pattern_latch),
		.drive(gp_drive),
		.drive_en(gp_en)
	);

	pin_fn_sel #(.WIDTH(2)) u_sel_a (
		.dir(pa_dir_reg),
		.pat_en(pat_low_reg),
		.data(pa_data_reg),
		.pat_data(pattern_latch_low),
		.drive(pa_drive),
		.drive_en(pa_en)
	);

	logic timer3_owns;
	assign timer3_owns = |{timer8_ch3.timer_output_level_select,
		timer8_ch3.timer_output_match_select};

	// Software standby leaves registers and pin drive untouched, so the held
	// direction bits keep outputs driving without any extra gating.
	always_comb begin
		pin_out = gp_drive;
		pin_oe = gp_en;
		if (timer3_owns) begin
			pin_out[`PIN_THREE] = timer8_ch3.timer_out;
			pin_oe[`PIN_THREE] = 1'b1;
		end else if (chip_sel4_enable) begin
			pin_out[`PIN_THREE] = chip_select_four;
			pin_oe[`PIN_THREE] = 1'b1;
		end
	end

	assign pa_pin_out = pa_drive;
	assign pa_pin_oe = pa_en;

	assign timer8_ch3_io_pin = !timer3_owns && !chip_sel4_enable
		&& !port_direction_control_reg[`PIN_THREE] && timer8_ch3.capture_input_enable
		&& pin_sync_lvl[`PIN_THREE];

	logic clk_b_sel;
	logic clk_a_sel;
	assign clk_b_sel = timer16.phase_count_mode
		|| timer16.prescale_ch2 == `PRESCALE_CLK_B || timer16.prescale_ch1 == `PRESCALE_CLK_B
		|| timer16.prescale_ch0 == `PRESCALE_CLK_B || timer8_ch3.ext_clock_selected;
	assign clk_a_sel = timer16.phase_count_mode
		|| timer16.prescale_ch2 == `PRESCALE_CLK_A || timer16.prescale_ch1 == `PRESCALE_CLK_A
		|| timer16.prescale_ch0 == `PRESCALE_CLK_A || timer8_ch1_ext_clock;

	assign ext_timer_clock_b = clk_b_sel && !pa_dir_reg[`PAT_LOW_ONE_BIT]
		&& pa_sync_lvl[`PAT_LOW_ONE_BIT];
	assign ext_timer_clock_a = clk_a_sel && !pa_dir_reg[`PAT_LOW_ZERO_BIT]
		&& pa_sync_lvl[`PAT_LOW_ZERO_BIT];
endmodule : port_b_gpio_pin_mux

//--- design/port_b_map.svh
// Register offsets, reset values and field positions for the port B block
`ifndef PORT_B_MAP_SVH
`define PORT_B_MAP_SVH

// ----------------------------------------------------------------
// Register word indices; the bus byte address is four times the index
// ----------------------------------------------------------------
`define DIR_CTRL_ADDR 20'hEE00A
`define OUT_DATA_ADDR 20'hFFFDA
`define PAT_EN_ADDR 20'hEE100
`define SIDE_CTRL_ADDR 20'hEE104
`define PA_DIR_ADDR 20'hEE108
`define PA_DATA_ADDR 20'hEE10C

// ----------------------------------------------------------------
// Reset values and read constants
// ----------------------------------------------------------------
`define DIR_RESET 8'h00
`define DATA_RESET 8'h00
`define PAT_RESET 8'h00
`define SIDE_RESET 8'h00
`define DIR_READ_VALUE 8'hFF
`define ADDR_BITS 22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SIDE_STANDBY_BIT 0
`define PAT_LOW_ONE_BIT 1
`define PAT_LOW_ZERO_BIT 0
`define PAT_HIGH_LSB 3
`define PIN_THREE 3
`define PRESCALE_CLK_B 3'h5
`define PRESCALE_CLK_A 3'h4

`endif

//--- design/port_b_pkg.sv
// Types shared by the port B block
package port_b_pkg;

	// ----------------------------------------------------------------
	// Controls from neighbouring units
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] timer_output_level_select;
		logic [1:0] timer_output_match_select;
		logic capture_input_enable;
		logic ext_clock_selected;
		logic timer_out;
	} timer8_ctrl_t;

	typedef struct packed {
		logic phase_count_mode;
		logic [2:0] prescale_ch2;
		logic [2:0] prescale_ch1;
		logic [2:0] prescale_ch0;
	} timer16_ctrl_t;

	typedef enum logic [1:0] {
		FN_INPUT,
		FN_OUTPUT,
		FN_PATTERN
	} pin_fn_t;

	typedef enum {
		BUS_IDLE,
		BUS_WRESP,
		BUS_RRESP
	} bus_state_t;

endpackage : port_b_pkg

//--- design/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous reset
	input wire logic [WIDTH-1:0] async_in, // Raw pin levels
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);
	logic [WIDTH-1:0] stage_one_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			stage_one_reg <= '0;
			sync_out <= '0;
		end else begin
			stage_one_reg <= async_in;
			sync_out <= stage_one_reg;
		end
	end
endmodule : pin_sync

//--- design/pin_fn_sel.sv
// Direction and pattern-enable decode for one group of pins
`timescale 1ns/100ps
module pin_fn_sel #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] dir, // Direction bits
	input wire logic [WIDTH-1:0] pat_en, // Pattern-output enables
	input wire logic [WIDTH-1:0] data, // Port data bits
	input wire logic [WIDTH-1:0] pat_data, // Pattern latch bits
	output logic [WIDTH-1:0] drive, // Drive level
	output logic [WIDTH-1:0] drive_en // Output enable
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			assign drive_en[i] = dir[i];
			assign drive[i] = (dir[i] && pat_en[i]) ? pat_data[i] : data[i];
		end
	endgenerate
endmodule : pin_fn_sel

//--- dv/port_b_assertions.sv
// Concurrent checks on the port B block ports
`timescale 1ns/100ps
module port_b_assertions (
	input wire logic clk, // clock
	input wire logic reset, // reset
	input wire logic hw_standby, // standby
	input wire logic [21:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid, // r valid
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [7:0] pin_in, // pin levels
	input wire logic [7:0] pin_out, // drive
	input wire logic [7:0] pin_oe, // enables
	input wire logic [1:0] pa_pin_in, // pin levels
	input wire logic [1:0] pa_pin_oe, // enables
	input wire port_b_pkg::timer8_ctrl_t timer8_ch3, // timer 3
	input wire logic timer8_ch1_ext_clock, // timer 1 clock
	input wire port_b_pkg::timer16_ctrl_t timer16, // timer 16
	input wire logic chip_sel4_enable, // cs4 on
	input wire logic chip_select_four, // cs4 level
	input wire logic timer8_ch3_io_pin, // capture in
	input wire logic ext_timer_clock_a, // clock a
	input wire logic ext_timer_clock_b // clock b
);
	logic [2:0] age_reg;
	logic tsel;
	logic sel_a;
	logic sel_b;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Synchronisers read zero just after reset and lag pin changes after a standby clear, so level checks wait
	always_ff @(posedge clk) begin
		if (reset || hw_standby) age_reg <= 3'h0;
		else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
	end
	assign tsel = |{timer8_ch3.timer_output_level_select, timer8_ch3.timer_output_match_select};
	assign sel_b = timer16.phase_count_mode || timer8_ch3.ext_clock_selected
		|| timer16.prescale_ch0 == 3'h5 || timer16.prescale_ch1 == 3'h5
		|| timer16.prescale_ch2 == 3'h5;
	assign sel_a = timer16.phase_count_mode || timer8_ch1_ext_clock
		|| timer16.prescale_ch0 == 3'h4 || timer16.prescale_ch1 == 3'h4
		|| timer16.prescale_ch2 == 3'h4;

	sequence dir_req;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[21:2] == 20'hEE00A;
	endsequence
	sequence settled(en, s);
		(en && $stable(s)) [*3];
	endsequence

	dir_read_ones_a: assert property (dir_req |=> s_axi_rvalid && s_axi_rdata == 32'h000000FF)
		else $error("direction read not all ones");
	timer_pin_override_a: assert property (tsel |-> pin_oe[3] && pin_out[3] == timer8_ch3.timer_out)
		else $error("pin 3 not driving timer output");
	chip_select_pin_a: assert property (!tsel && chip_sel4_enable
		|-> pin_oe[3] && pin_out[3] == chip_select_four)
		else $error("pin 3 not driving chip select");
	standby_clears_a: assert property (hw_standby |=> pin_oe[7:4] == 4'h0 && pa_pin_oe == 2'h0)
		else $error("standby left pins driving");
	capture_follows_a: assert property (settled(age_reg > 3'h3
		&& timer8_ch3.capture_input_enable && !pin_oe[3], pin_in[3])
		|-> timer8_ch3_io_pin == pin_in[3])
		else $error("capture input not following pin 3");
	capture_off_zero_a: assert property (!timer8_ch3.capture_input_enable |-> !timer8_ch3_io_pin)
		else $error("capture input active while disabled");
	clock_b_follows_a: assert property (settled(age_reg > 3'h3 && sel_b && !pa_pin_oe[1],
		pa_pin_in[1]) |-> ext_timer_clock_b == pa_pin_in[1])
		else $error("clock b not following pin");
	clock_a_follows_a: assert property (settled(age_reg > 3'h3 && sel_a && !pa_pin_oe[0],
		pa_pin_in[0]) |-> ext_timer_clock_a == pa_pin_in[0])
		else $error("clock a not following pin");
	clock_idle_low_a: assert property (!sel_a && !sel_b |-> !ext_timer_clock_a && !ext_timer_clock_b)
		else $error("external clock active while unselected");
endmodule : port_b_assertions

bind port_b_gpio_pin_mux port_b_assertions checks (
	.clk(clk), .reset(reset), .hw_standby(hw_standby), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe(pin_oe), .pa_pin_in(pa_pin_in), .pa_pin_oe(pa_pin_oe),
	.timer8_ch3(timer8_ch3), .timer8_ch1_ext_clock(timer8_ch1_ext_clock), .timer16(timer16),
	.chip_sel4_enable(chip_sel4_enable), .chip_select_four(chip_select_four),
	.timer8_ch3_io_pin(timer8_ch3_io_pin), .ext_timer_clock_a(ext_timer_clock_a),
	.ext_timer_clock_b(ext_timer_clock_b)
);

//--- dv/pin_world.sv
// Far side of a group of bidirectional pins
`timescale 1ns/100ps
module pin_world #(
	parameter int W = 8
) (
	input wire logic [W-1:0] drive, // device drive level
	input wire logic [W-1:0] drive_en, // device enables
	input wire logic [W-1:0] ext, // far-side level
	output logic [W-1:0] level // resolved pin level
);
	assign level = (drive & drive_en) | (ext & ~drive_en);
endmodule : pin_world

//--- dv/port_b_gpio_pin_mux_bench.sv
// Self-checking bench for the port B block
`timescale 1ns/100ps
`include "port_b_map.svh"
`define CHK(what, exp, got) \
	num_checks++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("Error %s expected %h seen %h", what, exp, got); \
	end
module port_b_gpio_pin_mux_bench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hw_standby = 1'b0;
	logic [21:0] awaddr = 22'h000000;
	logic [21:0] araddr = 22'h000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, io3, clk_a, clk_b;
	logic [1:0] bresp, rresp, pa_in, pa_out, pa_oe;
	logic [31:0] rdata;
	logic [7:0] pin_in, pin_out, pin_oe;
	logic [7:0] ext_b = 8'hA5;
	logic [7:0] latch = 8'hC3;
	logic [1:0] ext_a = 2'h0;
	logic [1:0] latch_lo = 2'h1;
	port_b_pkg::timer8_ctrl_t t8 = '0;
	port_b_pkg::timer16_ctrl_t t16 = '0;
	logic ch1_ext = 1'b0;
	logic cs_en = 1'b0;
	logic cs_lvl = 1'b0;
	int num_errors = 0;
	int num_checks = 0;
	// Fields: clock b, clock a, timer 3 ext, timer 1 ext, timer 16 controls
	localparam logic [13:0] CASES [10] = '{14'h3200, 14'h2005, 14'h2028, 14'h2140,
		14'h2800, 14'h1004, 14'h1020, 14'h1100, 14'h1400, 14'h0000};

	always #12.5 clk = ~clk;

	port_b_gpio_pin_mux DUT (
		.clk(clk), .reset(reset), .hw_standby(hw_standby), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pa_pin_in(pa_in), .pa_pin_out(pa_out), .pa_pin_oe(pa_oe),
		.pattern_latch(latch), .pattern_latch_low(latch_lo), .timer8_ch3(t8),
		.timer8_ch1_ext_clock(ch1_ext), .timer16(t16), .chip_sel4_enable(cs_en),
		.chip_select_four(cs_lvl), .timer8_ch3_io_pin(io3), .ext_timer_clock_a(clk_a),
		.ext_timer_clock_b(clk_b)
	);
	pin_world #(.W(8)) world_b (.drive(pin_out), .drive_en(pin_oe), .ext(ext_b), .level(pin_in));
	pin_world #(.W(2)) world_a (.drive(pa_out), .drive_en(pa_oe), .ext(ext_a), .level(pa_in));

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	// Handshakes are judged at the falling edge, whose values the next rising edge samples
	// Tasks take a register index; the byte address is four times it
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		logic [1:0] b_resp;
		@(posedge clk);
		awaddr <= {a, 2'h0};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid;
			b_resp = bresp;
			@(posedge clk);
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
		end while (!b_ok);
		bready <= 1'b0;
		`CHK("write resp", 2'h0, b_resp);
	endtask : wr

	task automatic rchk(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ar_ok;
		logic r_ok;
		logic [31:0] got;
		logic [1:0] resp;
		@(posedge clk);
		araddr <= {a, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ar_ok = arvalid && arready;
			r_ok = rvalid;
			got = rdata;
			resp = rresp;
			@(posedge clk);
			if (ar_ok) arvalid <= 1'b0;
		end while (!r_ok);
		rready <= 1'b0;
		`CHK("read data", d, got);
		`CHK("read resp", r, resp);
	endtask : rchk

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset;
		@(negedge clk);
		`CHK("pin_oe", 8'h00, pin_oe);
		// Synchronisers read zero for two edges after reset
		repeat (2) @(posedge clk);
		rchk(`OUT_DATA_ADDR, {24'h000000, ext_b}, 2'h0);
		rchk(`DIR_CTRL_ADDR, 32'h000000FF, 2'h0);
		rchk(20'h00010, 32'h00000000, 2'h2);
	endtask : test_reset

	task automatic test_output;
		wr(`DIR_CTRL_ADDR, 8'hF0);
		wr(`OUT_DATA_ADDR, 8'h5A);
		@(negedge clk);
		`CHK("pin_oe", 8'hF0, pin_oe);
		`CHK("plain drive", 4'h5, pin_out[7:4]);
		rchk(`DIR_CTRL_ADDR, 32'h000000FF, 2'h0);
	endtask : test_output

	// Pattern pins show a level unlike the data register, so pin checks tell them apart; reads return the data register
	task automatic test_pattern;
		wr(`PAT_EN_ADDR, 8'hF0);
		@(negedge clk);
		`CHK("pattern drive", latch[7:4], pin_out[7:4]);
		rchk(`OUT_DATA_ADDR, {24'h000000, 4'h5, ext_b[3:0]}, 2'h0);
		wr(`DIR_CTRL_ADDR, 8'h30);
		@(negedge clk);
		`CHK("pin_oe", 8'h30, pin_oe);
		`CHK("pattern drive", latch[5:4], pin_out[5:4]);
		rchk(`OUT_DATA_ADDR, {24'h000000, ext_b[7:6], 2'h1, ext_b[3:0]}, 2'h0);
		wr(`PAT_EN_ADDR, 8'h00);
		@(negedge clk);
		`CHK("plain drive", 2'h1, pin_out[5:4]);
	endtask : test_pattern

	task automatic test_pin3;
		int i;
		wr(`DIR_CTRL_ADDR, 8'h08);
		for (i = 1; i < 16; i++) begin
			@(posedge clk);
			t8.timer_output_level_select <= i[3:2];
			t8.timer_output_match_select <= i[1:0];
			t8.timer_out <= ~i[0];
			cs_en <= 1'b1;
			@(negedge clk);
			`CHK("timer drive", {1'b1, ~i[0]}, {pin_oe[3], pin_out[3]});
		end
		@(posedge clk);
		t8 <= '0;
		cs_lvl <= 1'b1;
		@(negedge clk);
		`CHK("chip select", 2'h3, {pin_oe[3], pin_out[3]});
		@(posedge clk);
		cs_lvl <= 1'b0;
		@(negedge clk);
		`CHK("chip select", 2'h2, {pin_oe[3], pin_out[3]});
		@(posedge clk);
		cs_en <= 1'b0;
		@(negedge clk);
		`CHK("pin 3 plain", 2'h3, {pin_oe[3], pin_out[3]});
		wr(`DIR_CTRL_ADDR, 8'h00);
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			t8.capture_input_enable <= 1'b1;
			ext_b[3] <= i[0];
			repeat (4) @(posedge clk);
			@(negedge clk);
			`CHK("capture input", i[0], io3);
		end
		@(posedge clk);
		t8 <= '0;
		@(negedge clk);
		`CHK("capture off", 1'b0, io3);
	endtask : test_pin3

	task automatic test_prev_port;
		int i;
		int j;
		logic [13:0] c;
		for (i = 0; i < 10; i++) begin
			c = CASES[i];
			for (j = 0; j < 2; j++) begin
				@(posedge clk);
				t16 <= c[9:0];
				t8.ext_clock_selected <= c[11];
				ch1_ext <= c[10];
				ext_a <= {2{j[0]}};
				repeat (4) @(posedge clk);
				@(negedge clk);
				`CHK("ext clocks", c[13:12] & {2{j[0]}}, {clk_b, clk_a});
			end
		end
		wr(`PA_DIR_ADDR, 8'h03);
		wr(`PA_DATA_ADDR, 8'h03);
		wr(`SIDE_CTRL_ADDR, 8'h04);
		@(negedge clk);
		`CHK("prev oe", 2'h3, pa_oe);
		`CHK("prev drive", {latch_lo[1], 1'b1}, pa_out);
	endtask : test_prev_port

	task automatic test_standby;
		wr(`DIR_CTRL_ADDR, 8'hF0);
		wr(`SIDE_CTRL_ADDR, 8'h01);
		@(negedge clk);
		`CHK("standby oe", 8'hF0, pin_oe);
		`CHK("standby drive", 4'h5, pin_out[7:4]);
		rchk(`OUT_DATA_ADDR, {24'h000000, 4'h5, ext_b[3:0]}, 2'h0);
		@(posedge clk);
		hw_standby <= 1'b1;
		repeat (2) @(posedge clk);
		hw_standby <= 1'b0;
		@(negedge clk);
		`CHK("standby oe", 8'h00, pin_oe);
		`CHK("prev oe", 2'h0, pa_oe);
		wr(`DIR_CTRL_ADDR, 8'hFF);
		rchk(`OUT_DATA_ADDR, 32'h00000000, 2'h0);
	endtask : test_standby

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_output();
		test_pattern();
		test_pin3();
		test_prev_port();
		test_standby();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
endmodule : port_b_gpio_pin_mux_bench
